// ===== logic/dtc_pkg.sv
/*
  Package for the dual 8-bit timer control block: register map, field layout,
  reset values, clock select and mode codes, prescaler widths.
  Assumes a 32-bit classic Wishbone slave with byte addresses, one register a word.
*/
package dtc_pkg;
  // Word index of the two control registers; byte address is four times it
  localparam logic [7:0] DTC_IDX_CTL_A = 8'h27;
  localparam logic [7:0] DTC_IDX_CTL_B = 8'h28;
  localparam logic [7:0] DTC_ADR_CTL_A = 8'(DTC_IDX_CTL_A * 4);
  localparam logic [7:0] DTC_ADR_CTL_B = 8'(DTC_IDX_CTL_B * 4);
  localparam logic [7:0] DTC_ADR_PER_A = 8'h00;
  localparam logic [7:0] DTC_ADR_PW_A = 8'h04;
  localparam logic [7:0] DTC_ADR_PER_B = 8'h08;
  localparam logic [7:0] DTC_ADR_PW_B = 8'h0c;
  localparam logic [7:0] DTC_ADR_CFG = 8'h10;
  localparam logic [7:0] DTC_ADR_STAT = 8'h14;
  localparam logic [7:0] DTC_ADR_CNT = 8'h18;
  // Reset values
  localparam logic [7:0] DTC_CTL_RST = 8'h00;
  localparam logic [7:0] DTC_TREG_RST = 8'h00;
  localparam logic [1:0] DTC_CFG_RST = 2'h0;
  // Configuration field positions
  localparam int unsigned DTC_CFG_DIV_BIT = 0;
  localparam int unsigned DTC_CFG_LP_BIT = 1;
  // Prescaler: width of the high-frequency divider and low-frequency divider
  localparam int unsigned DTC_PRE_W = 11;
  localparam int unsigned DTC_FS_W = 3;
  localparam int unsigned DTC_SH_11 = 11;
  localparam int unsigned DTC_SH_7 = 7;
  localparam int unsigned DTC_SH_5 = 5;
  localparam int unsigned DTC_SH_3 = 3;
  // Clock select codes
  typedef enum logic [2:0] {
    DTC_CK_SLOW = 3'h0, DTC_CK_FC7 = 3'h1, DTC_CK_FC5 = 3'h2, DTC_CK_FC3 = 3'h3,
    DTC_CK_FS = 3'h4, DTC_CK_FC1 = 3'h5, DTC_CK_FC = 3'h6, DTC_CK_PIN = 3'h7
  } dtc_clk_t;
  // Operating mode codes; codes with the top bit set are 16-bit modes of counter B
  typedef enum logic [2:0] {
    DTC_M_TMR8 = 3'h0, DTC_M_PDO8 = 3'h1, DTC_M_PWM8 = 3'h2, DTC_M_CASC = 3'h3,
    DTC_M_TMR16 = 3'h4, DTC_M_WARM = 3'h5, DTC_M_PWM16 = 3'h6, DTC_M_PPG16 = 3'h7
  } dtc_mode_t;
  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic ff;
    logic [2:0] ck;
    logic start;
    logic [2:0] mode;
  } dtc_ctl_t;
endpackage

// ===== logic/dtc_timer_ctl.sv
/*
  Control logic of two cascadable 8-bit timer/counters behind a classic
  Wishbone slave: control, period and pulse-width registers, count source
  selection, start/stop, cascade and output flip-flop preset.
  Assumes clk_i is the high-frequency clock and that the low-frequency clock
  and both count pins are asynchronous inputs.
*/
// Notes on behaviour
// R1 - Counter A has a control register, a period register and a pulse-width register.
// R2 - Control A: flip-flop bit 7, clock bits 6-4, start bit 3, mode 2-0; reset zero.
// R3 - Clock codes pick slow, fc/128, fc/32, fc/8, fs, fc/2, fc, pin.
// R4 - Low power allows only fs/8, fs, fc and pin sources.
// R5 - Software picks undivided fc in low power only for oscillator warm-up.
// R6 - Clearing start halts counter A and clears it; setting it starts counting.
// R7 - Mode A: 8-bit timer, divider output, 8-bit PWM, 16-bit cascade.
// R8 - Software keeps mode, clock and flip-flop fields of A while running.
// R9 - Stopping write keeps other fields; starting write may set them.
// R10 - Software leaves period A alone while counter A runs.
// R11 - Pulse-width A may change while running only in PWM modes.
// R12 - Cascade needs mode A at 011; counter B mode picks the 16-bit mode.
// R13 - Cascaded counter counts the clock picked by counter A clock field.
// R14 - Cascaded start and flip-flop follow counter B bits.
// R15 - Counter B has its own control, period and pulse-width registers.
// R16 - Software leaves period B alone while counter B runs.
// R17 - Pulse-width B may change while running only in PWM modes.
// R18 - Flip-flop control bit presets the timer output before counting.
// R19 - Mode B codes: 8-bit modes, reserved, 16-bit timer, warm-up, PWM, pattern.
// R20 - In 16-bit modes counter B counts counter A overflows.
// R21 - Control B has A's layout, the next index and resets to zero.
module dtc_timer_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_freq_clock_i,
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  output logic tff_a_o,
  output logic tff_b_o
);
  import dtc_pkg::*;

  // Picks a tick from the candidate sources, masking those absent in low power
  function automatic logic dtc_pick(input logic [2:0] ck, input logic lp,
                                    input logic [7:0] src);
    logic gone;
    gone = 1'b0;
    // R4 low power mask
    if (lp && (ck == DTC_CK_FC7 || ck == DTC_CK_FC5 || ck == DTC_CK_FC3 ||
               ck == DTC_CK_FC1)) begin
      gone = 1'b1;
    end
    return src[ck] & ~gone;
  endfunction

  // Bus and register state
  dtc_ctl_t ctl_a_q, ctl_a_d, ctl_b_q, ctl_b_d;
  logic [7:0] per_a_q, per_a_d, pw_a_q, pw_a_d;
  logic [7:0] per_b_q, per_b_d, pw_b_q, pw_b_d;
  logic [1:0] cfg_q, cfg_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Prescaler and synchronisers
  logic [DTC_PRE_W-1:0] pre_q, pre_d;
  logic [DTC_FS_W-1:0] fsd_q, fsd_d;
  logic [2:0] s1_q, s2_q, s3_q;
  // Counters
  logic [7:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;
  logic tff_a_q, tff_a_d, tff_b_q, tff_b_d;

  logic acc, wr, rd, lp, divopt;
  logic [2:0] rise;
  logic fs8;
  logic [7:0] src_a, src_b;
  logic casc, b16, run_a, run_b, tick_a, tick_b, ovf_a, match_b, ff_a;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign divopt = cfg_q[DTC_CFG_DIV_BIT];
  assign lp = cfg_q[DTC_CFG_LP_BIT];

  // Register writes take effect at the edge that raises ack
  always_comb begin
    ctl_a_d = ctl_a_q;
    ctl_b_d = ctl_b_q;
    per_a_d = per_a_q;
    pw_a_d = pw_a_q;
    per_b_d = per_b_q;
    pw_b_d = pw_b_q;
    cfg_d = cfg_q;
    ack_d = acc;
    rdat_d = 32'h0000_0000;
    if (wr) begin
      unique case (wb_adr_i)
        // R2 control A fields
        DTC_ADR_CTL_A: ctl_a_d = wb_dat_i[7:0];
        // R21 control B same layout
        DTC_ADR_CTL_B: ctl_b_d = wb_dat_i[7:0];
        // R1 timer registers A
        DTC_ADR_PER_A: per_a_d = wb_dat_i[7:0];
        DTC_ADR_PW_A: pw_a_d = wb_dat_i[7:0];
        // R15 timer registers B
        DTC_ADR_PER_B: per_b_d = wb_dat_i[7:0];
        DTC_ADR_PW_B: pw_b_d = wb_dat_i[7:0];
        DTC_ADR_CFG: cfg_d = wb_dat_i[1:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (wb_adr_i)
        DTC_ADR_CTL_A: rdat_d = {24'h00_0000, ctl_a_q};
        DTC_ADR_CTL_B: rdat_d = {24'h00_0000, ctl_b_q};
        DTC_ADR_PER_A: rdat_d = {24'h00_0000, per_a_q};
        DTC_ADR_PW_A: rdat_d = {24'h00_0000, pw_a_q};
        DTC_ADR_PER_B: rdat_d = {24'h00_0000, per_b_q};
        DTC_ADR_PW_B: rdat_d = {24'h00_0000, pw_b_q};
        DTC_ADR_CFG: rdat_d = {30'h0000_0000, cfg_q};
        DTC_ADR_STAT: rdat_d = {26'h000_0000, b16, casc, run_b, run_a, tff_b_q, tff_a_q};
        DTC_ADR_CNT: rdat_d = {16'h0000, cnt_b_q, cnt_a_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_a_q <= DTC_CTL_RST;
      ctl_b_q <= DTC_CTL_RST;
      per_a_q <= DTC_TREG_RST;
      pw_a_q <= DTC_TREG_RST;
      per_b_q <= DTC_TREG_RST;
      pw_b_q <= DTC_TREG_RST;
      cfg_q <= DTC_CFG_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ctl_a_q <= ctl_a_d;
      ctl_b_q <= ctl_b_d;
      per_a_q <= per_a_d;
      pw_a_q <= pw_a_d;
      per_b_q <= per_b_d;
      pw_b_q <= pw_b_d;
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Prescaler; the fs edge is taken only after two flops so fs may be async
  assign rise = s2_q & ~s3_q;
  assign fs8 = rise[0] & (&fsd_q);

  always_comb begin
    pre_d = pre_q + 1'b1;
    fsd_d = rise[0] ? fsd_q + 1'b1 : fsd_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
      fsd_q <= '0;
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      pre_q <= pre_d;
      fsd_q <= fsd_d;
      s1_q <= {pin_b_i, pin_a_i, low_freq_clock_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // R3 source candidates by clock code
  always_comb begin
    src_a[DTC_CK_SLOW] = (divopt | lp) ? fs8 : (&pre_q[DTC_SH_11-1:0]);
    src_a[DTC_CK_FC7] = &pre_q[DTC_SH_7-1:0];
    src_a[DTC_CK_FC5] = &pre_q[DTC_SH_5-1:0];
    src_a[DTC_CK_FC3] = &pre_q[DTC_SH_3-1:0];
    src_a[DTC_CK_FS] = rise[0];
    src_a[DTC_CK_FC1] = pre_q[0];
    src_a[DTC_CK_FC] = 1'b1;
    src_a[DTC_CK_PIN] = rise[1];
    src_b = {rise[2], src_a[6:0]};
  end

  // R12 cascade is taken from mode A, 16-bit from the top bit of mode B
  assign casc = (ctl_a_q.mode == DTC_M_CASC);
  // R19 codes 100 to 111 are the 16-bit modes
  assign b16 = ctl_b_q.mode[2];
  // R14 cascaded start and flip-flop come from counter B
  assign run_a = casc ? ctl_b_q.start : ctl_a_q.start;
  assign ff_a = casc ? ctl_b_q.ff : ctl_a_q.ff;
  assign run_b = ctl_b_q.start;
  // R13 cascaded clock from clock field A
  assign tick_a = run_a & dtc_pick(ctl_a_q.ck, lp, src_a);
  // R7 cascade wraps low byte at full scale, 8-bit modes at the period match
  assign ovf_a = tick_a & (casc ? (cnt_a_q == 8'hff) : (cnt_a_q == per_a_q));
  // R20 16-bit modes count overflows of counter A
  assign tick_b = run_b & (b16 ? ovf_a : dtc_pick(ctl_b_q.ck, lp, src_b));
  assign match_b = cnt_b_q == per_b_q;

  always_comb begin
    cnt_a_d = cnt_a_q;
    cnt_b_d = cnt_b_q;
    // R6 stop clears the count
    if (!run_a) begin
      cnt_a_d = 8'h00;
    end else if (tick_a) begin
      cnt_a_d = ovf_a ? 8'h00 : cnt_a_q + 8'h01;
    end
    if (!run_b) begin
      cnt_b_d = 8'h00;
    end else if (tick_b) begin
      cnt_b_d = match_b ? 8'h00 : cnt_b_q + 8'h01;
    end
    // R18 preset while stopped; a running timer keeps its output
    tff_a_d = run_a ? tff_a_q : ff_a;
    tff_b_d = run_b ? tff_b_q : ctl_b_q.ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_a_q <= 8'h00;
      cnt_b_q <= 8'h00;
      tff_a_q <= 1'b0;
      tff_b_q <= 1'b0;
    end else begin
      cnt_a_q <= cnt_a_d;
      cnt_b_q <= cnt_b_d;
      tff_a_q <= tff_a_d;
      tff_b_q <= tff_b_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign tff_a_o = tff_a_q;
  assign tff_b_o = tff_b_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (ack_q |=> !ack_q) // R2
    else $error("ack held longer than one cycle");
  a_ctl_reset_zero: assert property ($past(rst_i) |-> ctl_a_q == 8'h00 && ctl_b_q == 8'h00) // R2
    else $error("control registers not zero after reset");
  a_ctl_b_write: assert property (wr && wb_adr_i == DTC_ADR_CTL_B
    |=> ctl_b_q == $past(wb_dat_i[7:0]) && wb_ack_o) // R21
    else $error("control B write lost");
  a_ctl_a_read: assert property (rd && wb_adr_i == DTC_ADR_CTL_A
    |=> wb_dat_o == {24'h00_0000, $past(ctl_a_q)}) // R2
    else $error("control A read wrong");
  a_stop_clears: assert property (!run_a |=> cnt_a_q == 8'h00) // R6
    else $error("stopped counter A not cleared");
  a_lowpwr_mask: assert property (lp && ctl_a_q.ck inside {3'h1, 3'h2, 3'h3, 3'h5}
    |-> !tick_a) // R4
    else $error("divided fc used in low power");
  a_pin_source: assert property (run_a && ctl_a_q.ck == DTC_CK_PIN |-> tick_a == rise[1]) // R3
    else $error("pin source not used");
  a_casc_start: assert property (casc |-> run_a == ctl_b_q.start) // R14
    else $error("cascade start not from counter B");
  a_b_overflow: assert property (b16 && run_b |-> tick_b == ovf_a) // R20
    else $error("16-bit counter B not fed by overflow");
  a_ff_preset: assert property (!run_a ##1 !run_a |-> tff_a_q == $past(ff_a)) // R18
    else $error("flip-flop A not preset");
  a_count_step: assert property (run_a && tick_a && !ovf_a ##1 run_a
    |-> cnt_a_q == $past(cnt_a_q) + 8'h01) // R13
    else $error("counter A did not step");
  // Control A write, sources, wrap points and output flip-flops
  a_ctl_a_write: assert property (wr && wb_adr_i == DTC_ADR_CTL_A |=> ctl_a_q == $past(wb_dat_i[7:0])) // R2
    else $error("control A write lost");
  a_ovf_wraps_a: assert property (run_a && ovf_a |=> cnt_a_q == 8'h00) // R7
    else $error("counter A did not wrap");
  a_match_wraps_b: assert property (run_b && tick_b && match_b |=> cnt_b_q == 8'h00) // R20
    else $error("counter B did not wrap");
  a_casc_ff: assert property (casc |-> ff_a == ctl_b_q.ff) // R14
    else $error("cascade flip-flop not from counter B");
  a_fc_source: assert property (run_a && ctl_a_q.ck == DTC_CK_FC |-> tick_a) // R3
    else $error("fc source missed a tick");
  a_slow_fs8: assert property (run_a && (divopt || lp) && ctl_a_q.ck == DTC_CK_SLOW |-> tick_a == fs8) // R3
    else $error("slow source not fs over eight");
  a_tff_hold: assert property ($past(run_a) |-> tff_a_q == $past(tff_a_q)) // R18
    else $error("flip-flop A changed while running");
  a_tff_b_preset: assert property (!run_b |=> tff_b_q == $past(ctl_b_q.ff)) // R18
    else $error("flip-flop B not preset");
  a_b_own_clock: assert property (!b16 && run_b && ctl_b_q.ck == DTC_CK_PIN |-> tick_b == rise[2]) // R15
    else $error("counter B pin source not used");

  c_casc_run: cover property (casc && run_a && tick_a);
  c_ovf_a: cover property (ovf_a && !casc);
  c_b16_tick: cover property (b16 && tick_b);
  c_lp_fs8: cover property (lp && tick_a && ctl_a_q.ck == DTC_CK_SLOW);
  c_div_fs8: cover property (divopt && tick_a && ctl_a_q.ck == DTC_CK_SLOW);
endmodule // dtc_timer_ctl

// ===== sim/dtc_timer_ctl_bench.sv
/*
  Self-checking bench for the dual timer control block: register reset values,
  field read-back, output preset, pin counting, stop-and-clear, low-power and cascade.
  Assumes the classic Wishbone slave of the block answers with a single-cycle ack.
*/
module dtc_timer_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, lfc, pin_a, pin_b, ack, tff_a, tff_b;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rd;
  int fail_count, n_checks;
  logic [7:0] rst_map [8];

  dtc_timer_ctl u_dtc_timer_ctl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .low_freq_clock_i(lfc), .pin_a_i(pin_a), .pin_b_i(pin_b),
    .tff_a_o(tff_a), .tff_b_o(tff_b)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counter values whose exact phase is left open: only nonzero is required
  task automatic chk_nz(input string what, input logic [7:0] got);
    n_checks++;
    if (got === 8'h00 || $isunknown(got)) begin
      fail_count++;
      $display("Error %s expected nonzero seen %h", what, got);
    end
  endtask

  // One classic cycle; waits for ack with a bounded count, releases at that edge
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_r;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_xfer(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, lfc, pin_a, pin_b} = 6'h0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    fail_count = 0;
    n_checks = 0;
    rst_map = '{DTC_ADR_CTL_A, DTC_ADR_CTL_B, DTC_ADR_PER_A, DTC_ADR_PW_A,
                DTC_ADR_PER_B, DTC_ADR_PW_B, DTC_ADR_CFG, DTC_ADR_CNT};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_map[i]) rd_chk("reset", rst_map[i], 32'h0);
    wr(8'h40, 8'hff);
    rd_chk("unmapped", 8'h40, 32'h0);
    // field layout read back, stopped so any field may change
    wr(DTC_ADR_CTL_A, 8'hf7);
    rd_chk("ctl_a", DTC_ADR_CTL_A, 32'hf7);
    chk("tff_a high", 32'h1, {31'h0, tff_a});
    wr(DTC_ADR_CTL_A, 8'h00);
    rd_chk("tff_a low", DTC_ADR_STAT, 32'h0);
    chk("tff_a pin", 32'h0, {31'h0, tff_a});
    wr(DTC_ADR_CTL_B, 8'ha5);
    rd_chk("ctl_b", DTC_ADR_CTL_B, 32'ha5);
    chk("tff_b high", 32'h1, {31'h0, tff_b});
    wr(DTC_ADR_CTL_B, 8'h00);
    // Timer registers are written only while both counters are stopped
    wr(DTC_ADR_PER_A, 8'hff);
    rd_chk("period_a", DTC_ADR_PER_A, 32'hff);
    chk("tff_b low", 32'h0, {31'h0, tff_b});
    wr(DTC_ADR_PW_A, 8'h5a);
    rd_chk("pw_a", DTC_ADR_PW_A, 32'h5a);
    // Period B must be nonzero, or a cascaded high byte wraps at zero
    wr(DTC_ADR_PER_B, 8'hff);
    rd_chk("period_b", DTC_ADR_PER_B, 32'hff);
    wr(DTC_ADR_PW_B, 8'h3c);
    rd_chk("pw_b", DTC_ADR_PW_B, 32'h3c);
    // Pin source counts five rising edges exactly
    wr(DTC_ADR_CTL_A, 8'h78);
    repeat (5) begin
      repeat (4) @(posedge clk_i);
      pin_a <= 1'b1;
      repeat (4) @(posedge clk_i);
      pin_a <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    rd_chk("pin count", DTC_ADR_CNT, 32'h5);
    // Stop with fields kept: halts and clears
    wr(DTC_ADR_CTL_A, 8'h70);
    rd_chk("stop clear", DTC_ADR_CNT, 32'h0);
    // Divider option: code 000 counts every eighth slow-clock rise
    wr(DTC_ADR_CFG, 8'h01);
    wr(DTC_ADR_CTL_A, 8'h08);
    repeat (16) begin
      repeat (4) @(posedge clk_i);
      lfc <= 1'b1;
      repeat (4) @(posedge clk_i);
      lfc <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    rd_chk("slow eighth", DTC_ADR_CNT, 32'h2);
    wr(DTC_ADR_CTL_A, 8'h00);
    // Low power: divided fc source gives no ticks
    wr(DTC_ADR_CFG, 8'h02);
    rd_chk("cfg", DTC_ADR_CFG, 32'h2);
    wr(DTC_ADR_CTL_A, 8'h18);
    repeat (300) @(posedge clk_i);
    rd_chk("low power", DTC_ADR_CNT, 32'h0);
    wr(DTC_ADR_CTL_A, 8'h10);
    wr(DTC_ADR_CFG, 8'h00);
    // Cascade: A clock field fc, run from B start, B counts A overflows
    wr(DTC_ADR_CTL_A, 8'h63);
    wr(DTC_ADR_CTL_B, 8'h0c);
    repeat (600) @(posedge clk_i);
    wb_xfer(1'b0, DTC_ADR_CNT, 32'h0);
    chk_nz("cascade high", rd[15:8]);
    wb_xfer(1'b0, DTC_ADR_STAT, 32'h0);
    chk("cascade stat", 32'h3c, rd);
    wr(DTC_ADR_CTL_B, 8'h04);
    rd_chk("cascade stop", DTC_ADR_CNT, 32'h0);
    end_sim();
  end
endmodule // dtc_timer_ctl_bench
